// ### ics_alu.sv
// Two-operand ALU with byte lane merge into the destination word.
// Assumes byte address bit 0 clear selects the high byte.
`timescale 1ns/1ns
module ics_alu
  import ics_pkg::*;
(
  // Operation
  input  wire logic [4:0]  i_opc,
  input  wire logic        i_byte,
  // Operands
  input  wire logic [15:0] i_src,
  input  wire logic [15:0] i_dst,
  input  wire logic        i_src_lo,
  input  wire logic        i_dst_lo,
  // Result
  output logic [15:0]      o_result
);
  logic [15:0] a;
  logic [15:0] b;
  logic [15:0] r;

  always_comb
  begin
    a = i_src;
    b = i_dst;
    if (i_byte)
    begin
      a = {8'h00, (i_src_lo ? i_src[7:0] : i_src[15:8])};
      b = {8'h00, (i_dst_lo ? i_dst[7:0] : i_dst[15:8])};
    end
    case (i_opc)
      OPC_ADD, OPC_ADD_BYTE:         r = b + a;
      OPC_SUB, OPC_SUB_BYTE:         r = b - a;
      OPC_SET_ONES, OPC_SET_ONES_B:  r = b | a;
      OPC_SET_ZEROS, OPC_SET_ZEROS_B: r = b & ~a;
      OPC_XOR:                       r = b ^ a;
      OPC_WORD_MOVE, OPC_BYTE_MOVE:  r = a;
      default:                       r = b;
    endcase
    // merge one byte
    // The untouched byte keeps its old value so the word is written whole.
    if (!i_byte)
      o_result = r;
    else if (i_dst_lo)
      o_result = {i_dst[15:8], r[7:0]};
    else
      o_result = {r[7:0], i_dst[7:0]};
  end
endmodule

// ### ics_asserts.sv
// Port assertions for the cycle sequencer, bound to every instance.
// Assumes the clock enable is held high while checked.
`timescale 1ns/1ns
module ics_asserts (
  // Watched ports
  input wire logic        i_clk_sys,
  input wire logic        i_rst,
  input wire logic        i_start,
  input wire logic [15:0] i_pc,
  input wire logic        i_derive_done,
  input wire logic [15:0] i_derive_addr,
  input wire logic [15:0] i_mem_rdata,
  input wire logic        o_src_derive,
  input wire logic        o_dst_derive,
  input wire logic [15:0] o_mem_addr,
  input wire logic [15:0] o_mem_data,
  input wire logic        o_mem_rd,
  input wire logic        o_mem_wr,
  input wire logic        o_alu_cycle,
  input wire logic        o_busy,
  input wire logic        o_done,
  input wire logic        o_div_overflow,
  input wire logic        o_trap_done,
  input wire logic [15:0] o_new_pc
);
  logic [15:0] pc_cap;
  logic [15:0] dst_cap;
  logic [15:0] rd_cap;
  logic [5:0]  alu_run;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  always_ff @(posedge i_clk_sys)
  begin
    if (i_start && !o_busy)
      pc_cap <= i_pc;
    if (o_dst_derive && i_derive_done)
      dst_cap <= i_derive_addr;
    if (o_mem_rd)
      rd_cap <= i_mem_rdata;
    alu_run <= (i_rst || !o_alu_cycle) ? 6'h00 : alu_run + 6'h01;
  end
  a_fetch_pair: assert property (
    (i_start && !o_busy) |=> ##[0:1] (o_mem_rd && o_mem_addr == pc_cap)
    ##1 (o_alu_cycle && $stable(o_mem_addr))) else $error("fetch pair wrong");
  a_derive_quiet: assert property (
    (o_src_derive || o_dst_derive) |-> !(o_mem_rd || o_mem_wr || o_alu_cycle))
    else $error("bus cycle during derive");
  a_src_alu: assert property (
    (o_src_derive && i_derive_done) |=> (o_alu_cycle && !o_src_derive))
    else $error("no ALU after source");
  a_dst_final: assert property (
    (o_dst_derive && i_derive_done) |=> o_alu_cycle
    ##1 ((o_mem_wr || o_alu_cycle) && o_mem_addr[15:1] == dst_cap[15:1]))
    else $error("destination cycle wrong");
  a_data_hold: assert property (
    o_mem_rd |-> $stable(o_mem_data)) else $error("data bus moved on read");
  a_pair_write: assert property (
    o_mem_wr ##1 (o_alu_cycle && o_mem_addr == $past(o_mem_addr) + 16'h0002)
    |=> (o_mem_wr && $stable(o_mem_addr))) else $error("second word write wrong");
  a_alu_run: assert property (
    o_mem_wr |-> (alu_run <= 6'h02 || alu_run == 6'h12 || (alu_run >= 6'h23 && alu_run <= 6'h33)))
    else $error("ALU run before write wrong");
  a_ovf_abort: assert property (
    $rose(o_div_overflow) |-> !o_mem_wr throughout ##[0:3] o_done)
    else $error("overflow did not abandon");
  a_trap_pc: assert property (
    o_trap_done |-> (o_done && o_new_pc == rd_cap)) else $error("trap pc wrong");
  c_trap: cover property (o_trap_done);
  c_ovf: cover property ($rose(o_div_overflow));
  c_mul: cover property (o_mem_wr && alu_run == 6'h12);
endmodule
bind ics_sequencer ics_asserts i_ics_asserts (.i_clk_sys, .i_rst, .i_start, .i_pc,
  .i_derive_done, .i_derive_addr, .i_mem_rdata, .o_src_derive, .o_dst_derive, .o_mem_addr,
  .o_mem_data, .o_mem_rd, .o_mem_wr, .o_alu_cycle, .o_busy, .o_done, .o_div_overflow,
  .o_trap_done, .o_new_pc);

// ### ics_decode.sv
// Instruction class decoder for the cycle sequencer.
// Assumes a registered instruction word at its input.
`timescale 1ns/1ns
module ics_decode
  import ics_pkg::*;
(
  // Instruction
  input  wire logic [15:0] i_instr,
  // Class flags
  output logic             o_two_op,
  output logic             o_multiply,
  output logic             o_divide,
  output logic             o_trap,
  output logic             o_byte,
  output logic             o_compare,
  output logic             o_illegal
);
  logic [4:0] opc;

  assign opc        = i_instr[OPC_MSB:OPC_LSB];
  assign o_two_op   = (opc <= OPC_XOR) && (opc != OPC_TRAP);
  assign o_multiply = (opc == OPC_MULTIPLY);
  assign o_divide   = (opc == OPC_DIVIDE);
  assign o_trap     = (opc == OPC_TRAP);
  assign o_illegal  = (opc > OPC_DIVIDE);
  assign o_byte     = (opc < OPC_CMP_ONES) && opc[0];
  assign o_compare  = (opc == OPC_COMPARE) || (opc == OPC_BYTE_COMPARE) ||
                      (opc == OPC_CMP_ONES) || (opc == OPC_CMP_ZEROS);
endmodule

// ### ics_mem_model.sv
// Word-wide memory model on the far side of the sequencer's bus.
// Assumes byte addresses and a read answered in the cycle it is made.
`timescale 1ns/1ns
module ics_mem_model (
  // Bus from the sequencer
  input  wire logic        i_clk_sys,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_wdata,
  // Read data
  output logic [15:0]      o_rdata
);
  logic [15:0] mem [0:255];
  logic [15:0] last = 16'h0000;
  // Outside a read the lines show the inverse of the last word, so stale data never passes.
  assign o_rdata = i_rd ? mem[i_addr[8:1]] : ~last;
  always @(posedge i_clk_sys)
  begin
    if (i_rd)
      last <= mem[i_addr[8:1]];
    if (i_wr)
      mem[i_addr[8:1]] <= i_wdata;
  end
endmodule

// ### ics_pkg.sv
// Constants shared by the sequencer, its decoder and its ALU.
// Assumes a word-wide memory that answers a read in the same cycle.
package ics_pkg;

  // Instruction word fields.
  localparam int OPC_MSB  = 15;
  localparam int OPC_LSB  = 11;
  localparam int DREG_MSB = 9;
  localparam int DREG_LSB = 6;

  // Operation codes of the instruction word.
  localparam logic [4:0] OPC_ADD          = 5'h00;
  localparam logic [4:0] OPC_ADD_BYTE     = 5'h01;
  localparam logic [4:0] OPC_COMPARE      = 5'h02;
  localparam logic [4:0] OPC_BYTE_COMPARE = 5'h03;
  localparam logic [4:0] OPC_SUB          = 5'h04;
  localparam logic [4:0] OPC_SUB_BYTE     = 5'h05;
  localparam logic [4:0] OPC_SET_ONES     = 5'h06;
  localparam logic [4:0] OPC_SET_ONES_B   = 5'h07;
  localparam logic [4:0] OPC_SET_ZEROS    = 5'h08;
  localparam logic [4:0] OPC_SET_ZEROS_B  = 5'h09;
  localparam logic [4:0] OPC_WORD_MOVE    = 5'h0A;
  localparam logic [4:0] OPC_BYTE_MOVE    = 5'h0B;
  localparam logic [4:0] OPC_CMP_ONES     = 5'h0C;
  localparam logic [4:0] OPC_CMP_ZEROS    = 5'h0D;
  localparam logic [4:0] OPC_XOR          = 5'h0E;
  localparam logic [4:0] OPC_TRAP         = 5'h0F;
  localparam logic [4:0] OPC_MULTIPLY     = 5'h10;
  localparam logic [4:0] OPC_DIVIDE       = 5'h11;

  // Trap vectors and register numbers of the new workspace.
  localparam logic [15:0] TRAP_WP_VEC  = 16'h0040;
  localparam logic [15:0] TRAP_PC_VEC  = 16'h0042;
  localparam logic [3:0]  REG_LINK     = 4'hB;
  localparam logic [3:0]  REG_OLD_WP   = 4'hD;
  localparam logic [3:0]  REG_RETURN   = 4'hE;
  localparam logic [3:0]  REG_STATUS   = 4'hF;
  localparam logic [15:0] WORD_STEP    = 16'h0002;

  // Loop lengths: one clock is one machine cycle of 100 ns.
  localparam logic [3:0] MUL_LAST_STEP = 4'hF;
  localparam logic [3:0] DIV_LAST_STEP = 4'hF;

  typedef enum logic [40:0] {
    ST_IDLE     = 41'h000_0000_0001,
    ST_FETCH    = 41'h000_0000_0002,
    ST_DECODE   = 41'h000_0000_0004,
    ST_SRC_DRV  = 41'h000_0000_0008,
    ST_SRC_ALU  = 41'h000_0000_0010,
    ST_DST_DRV  = 41'h000_0000_0020,
    ST_DST_ALU  = 41'h000_0000_0040,
    ST_WR_RES   = 41'h000_0000_0080,
    ST_CMP_END  = 41'h000_0000_0100,
    ST_MU_RDREG = 41'h000_0000_0200,
    ST_MU_ALU1  = 41'h000_0000_0400,
    ST_MU_ALU2  = 41'h000_0000_0800,
    ST_MU_LOOP  = 41'h000_0000_1000,
    ST_MU_WRHI  = 41'h000_0000_2000,
    ST_MU_ALU3  = 41'h000_0000_4000,
    ST_MU_WRLO  = 41'h000_0000_8000,
    ST_DI_RDREG = 41'h000_0001_0000,
    ST_DI_CHK   = 41'h000_0002_0000,
    ST_DI_ALU6  = 41'h000_0004_0000,
    ST_DI_RDLO  = 41'h000_0008_0000,
    ST_DI_ALU8  = 41'h000_0010_0000,
    ST_DI_ALU9  = 41'h000_0020_0000,
    ST_DI_LOOP  = 41'h000_0040_0000,
    ST_DI_ALU10 = 41'h000_0080_0000,
    ST_DI_WRQ   = 41'h000_0100_0000,
    ST_DI_ALU12 = 41'h000_0200_0000,
    ST_DI_WRR   = 41'h000_0400_0000,
    ST_TR_ALU4  = 41'h000_0800_0000,
    ST_TR_ALU5  = 41'h000_1000_0000,
    ST_TR_RDWP  = 41'h000_2000_0000,
    ST_TR_ALU7  = 41'h000_4000_0000,
    ST_TR_OPERAND_LINK_REG  = 41'h000_8000_0000,
    ST_TR_ALU9  = 41'h001_0000_0000,
    ST_TR_WR15  = 41'h002_0000_0000,
    ST_TR_ALU11 = 41'h004_0000_0000,
    ST_TR_WR14  = 41'h008_0000_0000,
    ST_TR_ALU13 = 41'h010_0000_0000,
    ST_TR_WR13  = 41'h020_0000_0000,
    ST_TR_ALU15 = 41'h040_0000_0000,
    ST_TR_RDPC  = 41'h080_0000_0000,
    ST_TR_ALU17 = 41'h100_0000_0000
  } ics_state_t;

endpackage

// ### ics_sequencer.sv
// Machine-cycle sequencer for two-operand, multiply, divide and trap instructions.
// Assumes memory read data is valid in the cycle o_mem_rd is high, and an
// outside operand derivation unit that answers a derive request with i_derive_done.
`timescale 1ns/1ns
module ics_sequencer
  import ics_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  // Instruction start
  input  wire logic        i_start,
  input  wire logic [15:0] i_pc,
  input  wire logic [15:0] i_wp,
  input  wire logic [15:0] i_status,
  // Operand derivation unit
  input  wire logic        i_derive_done,
  input  wire logic [15:0] i_derive_data,
  input  wire logic [15:0] i_derive_addr,
  output logic             o_src_derive,
  output logic             o_dst_derive,
  output logic             o_byte_op,
  // Memory bus
  input  wire logic [15:0] i_mem_rdata,
  output logic [15:0]      o_mem_addr,
  output logic [15:0]      o_mem_data,
  output logic             o_mem_rd,
  output logic             o_mem_wr,
  output logic             o_alu_cycle,
  // Completion
  output logic             o_busy,
  output logic             o_done,
  output logic             o_div_overflow,
  output logic             o_trap_done,
  output logic [15:0]      o_new_wp,
  output logic [15:0]      o_new_pc
);
  import ics_pkg::*;

  ics_state_t  state;
  ics_state_t  next_state;
  logic [15:0] next_addr;
  logic [15:0] next_data;
  logic        next_rd;
  logic        next_wr;
  logic        next_alu;
  logic [15:0] pc;
  logic [15:0] wp;
  logic [15:0] status;
  logic [15:0] instr;
  logic [15:0] src_data;
  logic [15:0] src_addr;
  logic [15:0] dst_data;
  logic [15:0] dst_addr;
  logic [15:0] acc_hi;
  logic [15:0] acc_lo;
  logic        div_top;
  logic [1:0]  div_phase;
  logic [3:0]  step;
  logic [15:0] trap_wp;
  logic        ovf;
  logic        two_op;
  logic        is_mul;
  logic        is_div;
  logic        is_trap;
  logic        is_byte;
  logic        is_cmp;
  logic        illegal;
  logic [15:0] alu_res;
  logic [3:0]  dreg;
  logic [15:0] reg_addr;
  logic [16:0] mul_sum;
  logic [15:0] mul_hi;
  logic [15:0] mul_lo;
  logic        div_ge;
  logic        div_step_end;

  // workspace register address
  // A register index becomes a byte address two bytes per word.
  function automatic logic [15:0] ws_addr(input logic [15:0] base, input logic [3:0] n);
    ws_addr = base + {11'h000, n, 1'b0};
  endfunction

  ics_decode u_decode (
    .i_instr    (instr),
    .o_two_op   (two_op),
    .o_multiply (is_mul),
    .o_divide   (is_div),
    .o_trap     (is_trap),
    .o_byte     (is_byte),
    .o_compare  (is_cmp),
    .o_illegal  (illegal)
  );

  ics_alu u_alu (
    .i_opc    (instr[OPC_MSB:OPC_LSB]),
    .i_byte   (is_byte),
    .i_src    (src_data),
    .i_dst    (dst_data),
    .i_src_lo (src_addr[0]),
    .i_dst_lo (dst_addr[0]),
    .o_result (alu_res)
  );

  assign dreg     = instr[DREG_MSB:DREG_LSB];
  assign reg_addr = ws_addr(wp, dreg);

  assign mul_sum = {1'b0, acc_hi} + (acc_lo[0] ? {1'b0, dst_data} : 17'h0_0000);
  assign mul_hi  = mul_sum[16:1];
  assign mul_lo  = {mul_sum[0], acc_lo[15:1]};

  // restoring divide step
  // Each quotient bit costs two cycles, one more when it is a one,
  // which gives the 32 to 48 cycle spread.
  assign div_ge       = {div_top, acc_hi} >= {1'b0, src_data};
  assign div_step_end = (div_phase == 2'h2) || ((div_phase == 2'h1) && !div_ge);

  always_comb
  begin
    next_state = state;
    next_addr  = o_mem_addr;
    next_data  = o_mem_data;
    next_rd    = 1'b0;
    next_wr    = 1'b0;
    next_alu   = 1'b0;
    case (state)
      ST_IDLE:
        if (i_start)
        begin
          next_state = ST_FETCH;
          next_addr  = i_pc;
          next_rd    = 1'b1;
        end
      ST_FETCH:
      begin
        next_state = ST_DECODE;
        next_alu   = 1'b1;
      end
      ST_DECODE:
        next_state = illegal ? ST_IDLE : ST_SRC_DRV;
      ST_SRC_DRV:
        if (i_derive_done)
        begin
          next_state = ST_SRC_ALU;
          next_alu   = 1'b1;
        end
      ST_SRC_ALU:
        if (two_op)
          next_state = ST_DST_DRV;
        else if (is_mul || is_div)
        begin
          next_state = is_mul ? ST_MU_RDREG : ST_DI_RDREG;
          next_addr  = reg_addr;
          next_rd    = 1'b1;
        end
        else
        begin
          next_state = ST_TR_ALU4;
          next_alu   = 1'b1;
          next_data  = src_addr;
        end
      ST_DST_DRV:
        if (i_derive_done)
        begin
          next_state = ST_DST_ALU;
          next_alu   = 1'b1;
        end
      ST_DST_ALU:
        if (is_cmp)
        begin
          next_state = ST_CMP_END;
          next_alu   = 1'b1;
          next_addr  = dst_addr;
        end
        else
        begin
          next_state = ST_WR_RES;
          next_wr    = 1'b1;
          next_addr  = dst_addr;
          next_data  = alu_res;
        end
      ST_MU_RDREG:
      begin
        next_state = ST_MU_ALU1;
        next_alu   = 1'b1;
      end
      ST_MU_ALU1:
      begin
        next_state = ST_MU_ALU2;
        next_alu   = 1'b1;
        next_data  = src_data;
      end
      ST_MU_ALU2:
      begin
        next_state = ST_MU_LOOP;
        next_alu   = 1'b1;
        next_data  = 16'h0000;
      end
      ST_MU_LOOP:
        if (step == MUL_LAST_STEP)
        begin
          next_state = ST_MU_WRHI;
          next_wr    = 1'b1;
          next_addr  = reg_addr;
          next_data  = mul_hi;
        end
        else
        begin
          next_alu  = 1'b1;
          next_data = mul_hi;
        end
      ST_MU_WRHI:
      begin
        next_state = ST_MU_ALU3;
        next_alu   = 1'b1;
        next_addr  = reg_addr + WORD_STEP;
      end
      ST_MU_ALU3:
      begin
        next_state = ST_MU_WRLO;
        next_wr    = 1'b1;
        next_data  = acc_lo;
      end
      ST_DI_RDREG:
      begin
        next_state = ST_DI_CHK;
        next_alu   = 1'b1;
        next_data  = src_data;
      end
      ST_DI_CHK:
      begin
        next_state = ST_DI_ALU6;
        next_alu   = 1'b1;
      end
      ST_DI_ALU6:
        if (ovf)
          next_state = ST_IDLE;
        else
        begin
          next_state = ST_DI_RDLO;
          next_rd    = 1'b1;
          next_addr  = reg_addr + WORD_STEP;
        end
      ST_DI_RDLO:
      begin
        next_state = ST_DI_ALU8;
        next_alu   = 1'b1;
      end
      ST_DI_ALU8:
      begin
        next_state = ST_DI_ALU9;
        next_alu   = 1'b1;
      end
      ST_DI_ALU9:
      begin
        next_state = ST_DI_LOOP;
        next_alu   = 1'b1;
      end
      ST_DI_LOOP:
      begin
        next_alu = 1'b1;
        if (div_step_end && step == DIV_LAST_STEP)
          next_state = ST_DI_ALU10;
      end
      ST_DI_ALU10:
      begin
        next_state = ST_DI_WRQ;
        next_wr    = 1'b1;
        next_addr  = reg_addr;
        next_data  = acc_lo;
      end
      ST_DI_WRQ:
      begin
        next_state = ST_DI_ALU12;
        next_alu   = 1'b1;
        next_addr  = reg_addr + WORD_STEP;
      end
      ST_DI_ALU12:
      begin
        next_state = ST_DI_WRR;
        next_wr    = 1'b1;
        next_data  = acc_hi;
      end
      ST_TR_ALU4:
      begin
        next_state = ST_TR_ALU5;
        next_alu   = 1'b1;
      end
      ST_TR_ALU5:
      begin
        next_state = ST_TR_RDWP;
        next_rd    = 1'b1;
        next_addr  = TRAP_WP_VEC + {10'h000, dreg, 2'b00};
      end
      ST_TR_RDWP:
      begin
        next_state = ST_TR_ALU7;
        next_alu   = 1'b1;
        next_data  = src_addr;
      end
      ST_TR_ALU7:
      begin
        next_state = ST_TR_OPERAND_LINK_REG;
        next_wr    = 1'b1;
        next_addr  = ws_addr(trap_wp, REG_LINK);
      end
      ST_TR_OPERAND_LINK_REG:
      begin
        next_state = ST_TR_ALU9;
        next_alu   = 1'b1;
        next_addr  = ws_addr(trap_wp, REG_STATUS);
      end
      ST_TR_ALU9:
      begin
        next_state = ST_TR_WR15;
        next_wr    = 1'b1;
        next_data  = status;
      end
      ST_TR_WR15:
      begin
        next_state = ST_TR_ALU11;
        next_alu   = 1'b1;
        next_data  = pc + WORD_STEP;
      end
      ST_TR_ALU11:
      begin
        next_state = ST_TR_WR14;
        next_wr    = 1'b1;
        next_addr  = ws_addr(trap_wp, REG_RETURN);
      end
      ST_TR_WR14:
      begin
        next_state = ST_TR_ALU13;
        next_alu   = 1'b1;
        next_addr  = ws_addr(trap_wp, REG_OLD_WP);
      end
      ST_TR_ALU13:
      begin
        next_state = ST_TR_WR13;
        next_wr    = 1'b1;
        next_data  = wp;
      end
      ST_TR_WR13:
      begin
        next_state = ST_TR_ALU15;
        next_alu   = 1'b1;
      end
      ST_TR_ALU15:
      begin
        next_state = ST_TR_RDPC;
        next_rd    = 1'b1;
        next_addr  = TRAP_PC_VEC + {10'h000, dreg, 2'b00};
      end
      ST_TR_RDPC:
      begin
        next_state = ST_TR_ALU17;
        next_alu   = 1'b1;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      state          <= ST_IDLE;
      o_mem_addr     <= 16'h0000;
      o_mem_data     <= 16'h0000;
      o_mem_rd       <= 1'b0;
      o_mem_wr       <= 1'b0;
      o_alu_cycle    <= 1'b0;
      o_src_derive   <= 1'b0;
      o_dst_derive   <= 1'b0;
      o_busy         <= 1'b0;
      o_done         <= 1'b0;
      o_trap_done    <= 1'b0;
    end
    else if (i_ce)
    begin
      state        <= next_state;
      o_mem_addr   <= next_addr;
      o_mem_data   <= next_data;
      o_mem_rd     <= next_rd;
      o_mem_wr     <= next_wr;
      o_alu_cycle  <= next_alu;
      o_src_derive <= (next_state == ST_SRC_DRV);
      o_dst_derive <= (next_state == ST_DST_DRV);
      o_busy       <= (next_state != ST_IDLE);
      o_done       <= (next_state == ST_IDLE) && (state != ST_IDLE);
      o_trap_done  <= (state == ST_TR_ALU17);
    end
  end

  // Operand and context capture.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      pc       <= 16'h0000;
      wp       <= 16'h0000;
      status   <= 16'h0000;
      instr    <= 16'h0000;
      src_data <= 16'h0000;
      src_addr <= 16'h0000;
      dst_data <= 16'h0000;
      dst_addr <= 16'h0000;
      trap_wp  <= 16'h0000;
      o_byte_op      <= 1'b0;
      o_new_wp       <= 16'h0000;
      o_new_pc       <= 16'h0000;
      o_div_overflow <= 1'b0;
      ovf            <= 1'b0;
    end
    else if (i_ce)
    begin
      o_byte_op <= is_byte;
      if (state == ST_IDLE && i_start)
      begin
        pc     <= i_pc;
        wp     <= i_wp;
        status <= i_status;
      end
      if (state == ST_FETCH)
        instr <= i_mem_rdata;
      if (state == ST_SRC_DRV && i_derive_done)
      begin
        src_data <= i_derive_data;
        src_addr <= i_derive_addr;
      end
      if ((state == ST_DST_DRV && i_derive_done))
      begin
        dst_data <= i_derive_data;
        dst_addr <= i_derive_addr;
      end
      if (state == ST_MU_RDREG)
        dst_data <= i_mem_rdata;
      // overflow test
      // Quotient cannot fit when the high dividend is not below the divisor.
      if (state == ST_DI_CHK)
        ovf <= (acc_hi >= src_data);
      if (state == ST_DI_ALU6)
        o_div_overflow <= ovf;
      if (state == ST_TR_RDWP)
      begin
        trap_wp  <= i_mem_rdata;
        o_new_wp <= i_mem_rdata;
      end
      if (state == ST_TR_RDPC)
        o_new_pc <= i_mem_rdata;
    end
  end

  // Multiply and divide datapath.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      acc_hi    <= 16'h0000;
      acc_lo    <= 16'h0000;
      div_top   <= 1'b0;
      div_phase <= 2'h0;
      step      <= 4'h0;
    end
    else if (i_ce)
    begin
      case (state)
        ST_MU_ALU2:
        begin
          acc_hi <= 16'h0000;
          acc_lo <= src_data;
          step   <= 4'h0;
        end
        ST_MU_LOOP:
        begin
          acc_hi <= mul_hi;
          acc_lo <= mul_lo;
          step   <= step + 4'h1;
        end
        ST_DI_RDREG:
          acc_hi <= i_mem_rdata;
        ST_DI_RDLO:
        begin
          acc_lo    <= i_mem_rdata;
          div_phase <= 2'h0;
          div_top   <= 1'b0;
          step      <= 4'h0;
        end
        ST_DI_LOOP:
        begin
          if (div_phase == 2'h0)
          begin
            {div_top, acc_hi, acc_lo} <= {acc_hi, acc_lo, 1'b0};
            div_phase                 <= 2'h1;
          end
          else if (div_phase == 2'h1 && div_ge)
            div_phase <= 2'h2;
          else
          begin
            if (div_phase == 2'h2)
            begin
              acc_hi    <= acc_hi - src_data;
              div_top   <= 1'b0;
              acc_lo[0] <= 1'b1;
            end
            div_phase <= 2'h0;
            step      <= step + 4'h1;
          end
        end
        default:
          step <= step;
      endcase
    end
  end
endmodule

// ### tb_top.sv
// Self-checking bench: sequencer, memory model and a derivation responder.
// Assumes the bound checker and a memory with no wait state.
`timescale 1ns/1ns
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin miscompares++; \
  $display("unexpected %s expected %h seen %h", nm, e, s); end end
module tb_top;
  import ics_pkg::*;
  logic        clk, rst, start, ddone, sdrv, ddrv, rd, wr, alu, busy, done, ovf, tdone, td, bop;
  logic [15:0] pc, wp, dat, adr, maddr, mdata, rdata, npc, nwp, sa, sd, da, dv;
  logic [1:0]  ek [0:79];
  logic [15:0] ea [0:79];
  logic [15:0] ed [0:79];
  int          miscompares, comparisons, n, nd, slow, w;
  ics_sequencer i_ics_sequencer (.i_clk_sys(clk), .i_rst(rst), .i_ce(1'h1), .i_start(start),
    .i_pc(pc), .i_wp(wp), .i_status(16'hA5C3), .i_derive_done(ddone), .i_derive_data(dat),
    .i_derive_addr(adr), .o_src_derive(sdrv), .o_dst_derive(ddrv), .o_byte_op(bop),
    .i_mem_rdata(rdata), .o_mem_addr(maddr), .o_mem_data(mdata), .o_mem_rd(rd),
    .o_mem_wr(wr), .o_alu_cycle(alu), .o_busy(busy), .o_done(done), .o_div_overflow(ovf),
    .o_trap_done(tdone), .o_new_wp(nwp), .o_new_pc(npc));
  ics_mem_model i_ics_mem_model (.i_clk_sys(clk), .i_rd(rd), .i_wr(wr), .i_addr(maddr),
    .i_wdata(mdata), .o_rdata(rdata));
  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // Logs the first 80 bus cycles of a run and answers derive requests after slow waiting cycles.
  always @(negedge clk)
  begin
    if ((rd || wr || alu) && n < 80)
    begin
      ek[n] = {wr | alu, rd | alu};
      ea[n] = maddr;
      ed[n] = rd ? rdata : mdata;
      n++;
    end
    if (ddone)
    begin
      ddone = 1'h0;
      dat = ~dat;
      adr = ~adr;
    end
    else if ((sdrv || ddrv) && w++ >= slow)
    begin
      ddone = 1'h1;
      w = 0;
      nd += ddrv;
      dat = sdrv ? sd : dv;
      adr = sdrv ? sa : da;
    end
  end
  task automatic finish_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic ev(input int i, input logic [1:0] k, input logic [15:0] a);
    `CHK("kind", k, ek[i])
    `CHK("address", a, ea[i])
  endtask
  task automatic run(input logic [4:0] op, input logic [3:0] d);
    int k = 0;
    i_ics_mem_model.mem[pc[8:1]] = {op, 1'h0, d, 6'h00};
    n = 0;
    nd = 0;
    w = 0;
    start = 1'h1;
    @(negedge clk);
    start = 1'h0;
    while (done !== 1'h1 && k < 300)
    begin
      @(negedge clk);
      k++;
    end
    td = tdone;
    `CHK("done", 1'h1, done)
    @(negedge clk);
  endtask
  task automatic two_op;
    logic [4:0]  op [10] = '{OPC_ADD, OPC_ADD_BYTE, OPC_BYTE_MOVE, OPC_WORD_MOVE, OPC_SUB,
      OPC_XOR, OPC_COMPARE, OPC_BYTE_COMPARE, OPC_CMP_ONES, OPC_CMP_ZEROS};
    logic [15:0] v [6][5] = '{'{16'h0200, 16'h1234, 16'h0300, 16'h0F0F, 16'h2143},
      '{16'h0200, 16'h40FF, 16'h0301, 16'h12F3, 16'h1233},
      '{16'h0201, 16'hAB5C, 16'h0300, 16'h1177, 16'h5C77},
      '{16'h0200, 16'hBEEF, 16'h0300, 16'h1111, 16'hBEEF},
      '{16'h0200, 16'h1001, 16'h0300, 16'h5000, 16'h3FFF},
      '{16'h0200, 16'hFF00, 16'h0300, 16'h0FF0, 16'hF0F0}};
    for (int i = 0; i < 10; i++)
    begin
      {sa, sd, da, dv} = {v[i % 6][0], v[i % 6][1], v[i % 6][2], v[i % 6][3]};
      slow = i % 4;
      run(op[i], 4'h1);
      ev(0, 2'h1, pc);
      `CHK("fetch alu", 2'h3, ek[1])
      `CHK("source alu", 2'h3, ek[2])
      `CHK("dest reads", 1, nd)
      `CHK("cycles", 5, n)
      `CHK("last kind", (i < 6) ? 2'h2 : 2'h3, ek[4])
      `CHK("last address", da[15:1], ea[4][15:1])
      `CHK("byte op", (i == 1 || i == 2 || i == 7), bop)
      if (i < 6)
        `CHK("result", v[i][4], ed[4])
    end
    $display("two-operand test done");
  endtask
  task automatic mul_div;
    sd = 16'h0100;
    i_ics_mem_model.mem[8'h43] = 16'h1234;
    run(OPC_MULTIPLY, 4'h3);
    ev(3, 2'h1, 16'h0086);
    `CHK("multiplier", sd, ed[5])
    for (int j = 6; j < 22; j++) `CHK("loop", 2'h3, ek[j])
    ev(22, 2'h2, 16'h0086);
    `CHK("high half", 16'h0012, ed[22])
    ev(23, 2'h3, 16'h0088);
    ev(24, 2'h2, 16'h0088);
    `CHK("low half", 16'h3400, ed[24])
    `CHK("cycles", 25, n)
    sd = 16'h0003;
    i_ics_mem_model.mem[8'h42] = 16'h0005;
    run(OPC_DIVIDE, 4'h2);
    `CHK("overflow", 1'h1, ovf)
    `CHK("cycles", 6, n)
    ev(3, 2'h1, 16'h0084);
    i_ics_mem_model.mem[8'h42] = 16'h0001;
    i_ics_mem_model.mem[8'h43] = 16'h0000;
    run(OPC_DIVIDE, 4'h2);
    `CHK("overflow", 1'h0, ovf)
    ev(6, 2'h1, 16'h0086);
    `CHK("step range", 1, n >= 45 && n <= 61)
    ev(n - 3, 2'h2, 16'h0084);
    `CHK("quotient", 16'h5555, ed[n - 3])
    ev(n - 2, 2'h3, 16'h0086);
    ev(n - 1, 2'h2, 16'h0086);
    `CHK("remainder", 16'h0001, ed[n - 1])
    $display("multiply and divide test done");
  endtask
  task automatic trap;
    sa = 16'h0222;
    slow = 3;
    i_ics_mem_model.mem[8'h2A] = 16'h00C0;
    i_ics_mem_model.mem[8'h2B] = 16'h0400;
    run(OPC_TRAP, 4'h5);
    ev(5, 2'h1, 16'h0054);
    ev(7, 2'h2, 16'h00D6);
    `CHK("link", sa, ed[7])
    ev(9, 2'h2, 16'h00DE);
    `CHK("status", 16'hA5C3, ed[9])
    ev(11, 2'h2, 16'h00DC);
    `CHK("return", pc + 16'h0002, ed[11])
    ev(13, 2'h2, 16'h00DA);
    `CHK("old wp", wp, ed[13])
    ev(15, 2'h1, 16'h0056);
    `CHK("cycles", 17, n)
    `CHK("new pc", 16'h0400, npc)
    `CHK("new wp", 16'h00C0, nwp)
    `CHK("trap done", 1'h1, td)
    $display("trap test done");
  endtask
  // The run needs some 250 cycles; the limit leaves sixteen times that.
  initial
  begin
    #400000;
    miscompares++;
    finish_test;
  end
  initial
  begin
    {rst, start, ddone, w, n, slow, miscompares, comparisons} = '0;
    rst = 1'h1;
    {pc, wp, dat, adr} = {16'h0100, 16'h0080, 16'h0000, 16'h0000};
    repeat (10) @(negedge clk);
    rst = 1'h0;
    @(negedge clk);
    two_op;
    mul_div;
    trap;
    finish_test;
  end
endmodule
